// File: src/ifsb_top.sv
`default_nettype none

// Summary of operation
// RULE1 - flag reads one after its request
// RULE2 - unimplemented bits ignore writes, read zero
// RULE3 - implemented flags read/write, reset zero
// RULE4 - no CAN controller: CAN flags disabled
// RULE5 - no audio DAC: DAC flags disabled
// RULE6 - bank one upper byte flag order
// RULE7 - bank one lower byte flag order
// RULE8 - bank two layout, DMA, port, CAN, SPI
// RULE9 - bank three layout, clock, DMA, codec
// RULE10 - bank four layout, DAC, CAN, DMA, errors
// RULE11 - bank zero: compare, capture, pin zero
// RULE12 - pin edge chosen by polarity bit
// RULE13 - write zero clears; hardware set wins
module ifsb_top
    import ifsb_pkg::*;
#(
    parameter bit HAS_CAN = 1'b1,
    parameter bit HAS_DAC = 1'b1
)
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`IFSB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    ext_pin0,
    input  wire logic                    ext_pin1,
    input  wire logic                    ext_pin2,
    input  wire logic                    compare_ch1_req,
    input  wire logic                    capture_ch1_req,
    input  wire logic                    serial2_tx_req,
    input  wire logic                    serial2_rx_req,
    input  wire logic                    timer_five_req,
    input  wire logic                    timer_four_req,
    input  wire logic                    compare_ch4_req,
    input  wire logic                    compare_ch3_req,
    input  wire logic                    dma_ch2_done_req,
    input  wire logic                    capture_ch8_req,
    input  wire logic                    capture_ch7_req,
    input  wire logic                    change_notify_req,
    input  wire logic                    comparator_req,
    input  wire logic                    i2c_master_event_req,
    input  wire logic                    i2c_slave_event_req,
    input  wire logic                    dma_ch4_done_req,
    input  wire logic                    parallel_port_req,
    input  wire logic                    dma_ch3_done_req,
    input  wire logic                    can_event_req,
    input  wire logic                    can_rx_ready_req,
    input  wire logic                    spi_two_event_req,
    input  wire logic                    spi_two_error_req,
    input  wire logic                    calendar_clock_req,
    input  wire logic                    dma_ch5_done_req,
    input  wire logic                    codec_if_event_req,
    input  wire logic                    codec_if_error_req,
    input  wire logic                    dac_left_req,
    input  wire logic                    dac_right_req,
    input  wire logic                    can_tx_request_req,
    input  wire logic                    dma_ch7_done_req,
    input  wire logic                    dma_ch6_done_req,
    input  wire logic                    checksum_gen_req,
    input  wire logic                    serial2_error_req,
    input  wire logic                    serial1_error_req,
    output ifsb_flag_t                   irq_flags_bank_zero,
    output ifsb_flag_t                   irq_flags_bank_one,
    output ifsb_flag_t                   irq_flags_bank_two,
    output ifsb_flag_t                   irq_flags_bank_three,
    output ifsb_flag_t                   irq_flags_bank_four,
    output logic                         irq
);

    ifsb_flag_t                flag      [`IFSB_NUM_BANKS];
    ifsb_flag_t                req       [`IFSB_NUM_BANKS];
    ifsb_flag_t                live      [`IFSB_NUM_BANKS];
    ifsb_flag_t                next_flag [`IFSB_NUM_BANKS];
    logic [`IFSB_EVT_W-1:0]    new_set;
    logic [`IFSB_POL_W-1:0]    ext_pin_polarity;
    logic [`IFSB_EVT_W-1:0]    evt_mask;
    logic [`IFSB_EVT_W-1:0]    evt_stat;
    logic [`IFSB_EVT_W-1:0]    next_evt_stat;
    logic [`IFSB_NUM_PINS-1:0] pins;
    logic [`IFSB_NUM_PINS-1:0] pin_edge;
    ifsb_sel_t                 sel;
    logic                      setup_phase;
    logic                      access_done;
    logic                      wr_done;
    logic                      rd_done;
    ifsb_flag_t                lane_mask;
    logic [31:0]               next_rdata;

    assign pins = {ext_pin2, ext_pin1, ext_pin0};

    // external pin edge detectors
    genvar p;
    generate
        for (p = 0; p < `IFSB_NUM_PINS; p++)
        begin : g_pin
            ifsb_pin_edge u_edge (
                .pclk       (pclk),
                .presetn    (presetn),
                .pin        (pins[p]),
                .polarity   (ext_pin_polarity[p]),
                .edge_pulse (pin_edge[p])
            );
        end
    endgenerate

    // request vectors in bit order
    assign req[0] = {13'h0000, compare_ch1_req, capture_ch1_req, pin_edge[0]}; // see RULE11

    assign req[1] = {serial2_tx_req, serial2_rx_req, pin_edge[2], timer_five_req,
                     timer_four_req, compare_ch4_req, compare_ch3_req,
                     dma_ch2_done_req, // see RULE6
                     capture_ch8_req, capture_ch7_req, 1'h0, pin_edge[1],
                     change_notify_req, comparator_req, i2c_master_event_req,
                     i2c_slave_event_req}; // see RULE7

    assign req[2] = {1'h0, dma_ch4_done_req, parallel_port_req, 8'h00,
                     dma_ch3_done_req, can_event_req, can_rx_ready_req,
                     spi_two_event_req, spi_two_error_req}; // see RULE8

    assign req[3] = {1'h0, calendar_clock_req, dma_ch5_done_req,
                     codec_if_event_req, codec_if_error_req, 11'h000}; // see RULE9

    assign req[4] = {dac_left_req, dac_right_req, 7'h00, can_tx_request_req,
                     dma_ch7_done_req, dma_ch6_done_req, checksum_gen_req,
                     serial2_error_req, serial1_error_req, 1'h0}; // see RULE10

    // live bits: implemented and present in this variant
    assign live[0] = `IFSB_IMPL_BANK0; // see RULE2
    assign live[1] = `IFSB_IMPL_BANK1; // see RULE2
    assign live[2] = `IFSB_IMPL_BANK2 & (HAS_CAN ? 16'hFFFF : ~`IFSB_CAN_BITS2); // see RULE4
    assign live[3] = `IFSB_IMPL_BANK3; // see RULE2
    assign live[4] = `IFSB_IMPL_BANK4
                   & (HAS_CAN ? 16'hFFFF : ~`IFSB_CAN_BITS4) // see RULE4
                   & (HAS_DAC ? 16'hFFFF : ~`IFSB_DAC_BITS4); // see RULE5

    // apb address decode
    always_comb
    begin
        case (paddr)
            `IFSB_OFS_BANK0:    sel = IFSB_SEL_BANK0;
            `IFSB_OFS_BANK1:    sel = IFSB_SEL_BANK1;
            `IFSB_OFS_BANK2:    sel = IFSB_SEL_BANK2;
            `IFSB_OFS_BANK3:    sel = IFSB_SEL_BANK3;
            `IFSB_OFS_BANK4:    sel = IFSB_SEL_BANK4;
            `IFSB_OFS_POLARITY: sel = IFSB_SEL_POLARITY;
            `IFSB_OFS_EVT_MASK: sel = IFSB_SEL_EVT_MASK;
            `IFSB_OFS_EVT_STAT: sel = IFSB_SEL_EVT_STAT;
            default:            sel = IFSB_SEL_NONE;
        endcase
    end

    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign wr_done     = access_done & pwrite;
    assign rd_done     = access_done & ~pwrite;
    assign lane_mask   = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // flag banks
    genvar b;
    generate
        for (b = 0; b < `IFSB_NUM_BANKS; b++)
        begin : g_bank
            always_comb
            begin
                next_flag[b] = flag[b];
                if (wr_done && sel == ifsb_sel_t'(b))
                    next_flag[b] = (flag[b] & ~lane_mask)
                                 | (pwdata[15:0] & lane_mask); // see RULE3
                next_flag[b] = (next_flag[b] | req[b]) & live[b]; // see RULE13
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    flag[b] <= `IFSB_RST_FLAGS; // see RULE3
                else
                    flag[b] <= next_flag[b]; // see RULE1
            end

            assign new_set[b] = |(req[b] & live[b] & ~flag[b]);
        end
    endgenerate

    assign irq_flags_bank_zero  = flag[0];
    assign irq_flags_bank_one   = flag[1];
    assign irq_flags_bank_two   = flag[2];
    assign irq_flags_bank_three = flag[3];
    assign irq_flags_bank_four  = flag[4];

    // edge polarity register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ext_pin_polarity <= `IFSB_RST_POLARITY;
        else if (wr_done && sel == IFSB_SEL_POLARITY && pstrb[0])
            ext_pin_polarity <= pwdata[`IFSB_POL_W-1:0]; // see RULE12
    end

    // event mask register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_mask <= `IFSB_RST_EVT;
        else if (wr_done && sel == IFSB_SEL_EVT_MASK && pstrb[0])
            evt_mask <= pwdata[`IFSB_EVT_W-1:0];
    end

    // sticky bank events, cleared by read, set wins
    always_comb
    begin
        next_evt_stat = evt_stat;
        if (rd_done && sel == IFSB_SEL_EVT_STAT)
            next_evt_stat = `IFSB_RST_EVT;
        next_evt_stat = next_evt_stat | new_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_stat <= `IFSB_RST_EVT;
        else
            evt_stat <= next_evt_stat;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'h0;
        else
            irq <= |(next_evt_stat & evt_mask);
    end

    // read mux, unused bits zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (sel)
            IFSB_SEL_BANK0:    next_rdata[15:0] = flag[0]; // see RULE2
            IFSB_SEL_BANK1:    next_rdata[15:0] = flag[1];
            IFSB_SEL_BANK2:    next_rdata[15:0] = flag[2];
            IFSB_SEL_BANK3:    next_rdata[15:0] = flag[3];
            IFSB_SEL_BANK4:    next_rdata[15:0] = flag[4];
            IFSB_SEL_POLARITY: next_rdata[`IFSB_POL_W-1:0] = ext_pin_polarity;
            IFSB_SEL_EVT_MASK: next_rdata[`IFSB_EVT_W-1:0] = evt_mask;
            IFSB_SEL_EVT_STAT: next_rdata[`IFSB_EVT_W-1:0] = evt_stat;
            default:           next_rdata = 32'h0000_0000;
        endcase
    end

    // one wait-free access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'h0;
        else
            pready <= setup_phase;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr <= 1'h0;
        else if (setup_phase)
            pslverr <= (sel == IFSB_SEL_NONE);
        else
            pslverr <= 1'h0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup_phase && !pwrite)
            prdata <= next_rdata;
        else
            prdata <= 32'h0000_0000;
    end

endmodule

`default_nettype wire

// File: src/ifsb_regs.svh
`ifndef IFSB_REGS_SVH
`define IFSB_REGS_SVH

// apb byte offsets
`define IFSB_ADDR_W       12
`define IFSB_OFS_BANK0    12'h000
`define IFSB_OFS_BANK1    12'h004
`define IFSB_OFS_BANK2    12'h008
`define IFSB_OFS_BANK3    12'h00C
`define IFSB_OFS_BANK4    12'h010
`define IFSB_OFS_POLARITY 12'h014
`define IFSB_OFS_EVT_MASK 12'h018
`define IFSB_OFS_EVT_STAT 12'h01C

// implemented flag positions per bank
`define IFSB_IMPL_BANK0   16'h0007
`define IFSB_IMPL_BANK1   16'hFFDF
`define IFSB_IMPL_BANK2   16'h601F
`define IFSB_IMPL_BANK3   16'h7800
`define IFSB_IMPL_BANK4   16'hC07E

// variant dependent flags
`define IFSB_CAN_BITS2    16'h000C
`define IFSB_CAN_BITS4    16'h0040
`define IFSB_DAC_BITS4    16'hC000

// field counts and widths
`define IFSB_NUM_BANKS    5
`define IFSB_NUM_PINS     3
`define IFSB_POL_W        3
`define IFSB_EVT_W        5

// reset values
`define IFSB_RST_FLAGS    16'h0000
`define IFSB_RST_POLARITY 3'h0
`define IFSB_RST_EVT      5'h00

`endif

// File: src/ifsb_pkg.sv
`default_nettype none
`include "ifsb_regs.svh"

package ifsb_pkg;

    typedef logic [15:0] ifsb_flag_t;

    typedef enum {
        IFSB_SEL_BANK0,
        IFSB_SEL_BANK1,
        IFSB_SEL_BANK2,
        IFSB_SEL_BANK3,
        IFSB_SEL_BANK4,
        IFSB_SEL_POLARITY,
        IFSB_SEL_EVT_MASK,
        IFSB_SEL_EVT_STAT,
        IFSB_SEL_NONE
    } ifsb_sel_t;

endpackage

`default_nettype wire

// File: src/ifsb_pin_edge.sv
`default_nettype none

module ifsb_pin_edge
    import ifsb_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    input  wire logic polarity,
    output logic      edge_pulse
);

    logic sync_a;
    logic sync_b;
    logic prev;
    logic primed;

    // two stage synchroniser
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= 1'h0;
            sync_b <= 1'h0;
        end
        else
        begin
            sync_a <= pin;
            sync_b <= sync_a;
        end
    end

    // history and start-up guard
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev   <= 1'h0;
            primed <= 1'h0;
        end
        else
        begin
            prev   <= sync_b;
            primed <= 1'h1;
        end
    end

    // polarity 1 falling, 0 rising
    always_comb
    begin
        if (polarity)
            edge_pulse = primed & prev & ~sync_b; // see RULE12
        else
            edge_pulse = primed & ~prev & sync_b; // see RULE12
    end

endmodule

`default_nettype wire

// File: test/ifsb_checker.sv
`default_nettype none
`include "ifsb_regs.svh"
module ifsb_checker
    import ifsb_pkg::*;
(
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [`IFSB_ADDR_W-1:0] paddr,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic                    timer_four_req,
    input wire ifsb_flag_t              irq_flags_bank_zero,
    input wire ifsb_flag_t              irq_flags_bank_one,
    input wire ifsb_flag_t              irq_flags_bank_two,
    input wire ifsb_flag_t              irq_flags_bank_three,
    input wire ifsb_flag_t              irq_flags_bank_four
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wr_one;
    assign wr_one = psel && penable && pready && pwrite && paddr == `IFSB_OFS_BANK1;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence done_s;
        psel && penable && pready;
    endsequence
    ready_after_setup_a: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    ready_single_a: assert property (done_s |=> !pready)
        else $error("ready held");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_zero_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside read");
    rdata_upper_zero_a: assert property (prdata[31:16] == 16'h0)
        else $error("upper read data set");
    unimpl_zero_a: assert property (!(|{irq_flags_bank_zero & ~`IFSB_IMPL_BANK0,
        irq_flags_bank_one & ~`IFSB_IMPL_BANK1, irq_flags_bank_two & ~`IFSB_IMPL_BANK2,
        irq_flags_bank_three & ~`IFSB_IMPL_BANK3, irq_flags_bank_four & ~`IFSB_IMPL_BANK4}))
        else $error("unimplemented flag set");
    reset_clear_a: assert property ($rose(presetn) |-> !(|{irq_flags_bank_zero,
        irq_flags_bank_one, irq_flags_bank_two, irq_flags_bank_three, irq_flags_bank_four}))
        else $error("flags not clear after reset");
    req_sets_flag_a: assert property (timer_four_req |=> irq_flags_bank_one[11])
        else $error("request did not set flag");
    flag_sticky_a: assert property (irq_flags_bank_one[11] && !wr_one |=>
        irq_flags_bank_one[11])
        else $error("flag dropped without write");
    flag_cause_a: assert property ($rose(irq_flags_bank_one[11]) |->
        $past(timer_four_req) || $past(wr_one))
        else $error("flag set without cause");
endmodule
`default_nettype wire

// File: test/ifsb_src.sv
`default_nettype none
module ifsb_src
(
    input  wire logic        pclk,
    output logic      [79:0] req,
    output logic      [2:0]  pins
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        req = 80'h0;
        pins = 3'h0;
    end
    // one-cycle request from a source
    task automatic pulse(input int i);
        @(posedge pclk);
        req[i] <= 1'b1;
        @(posedge pclk);
        req[i] <= 1'b0;
    endtask
    // pin level change, then settle through sync
    task automatic drive_pin(input int p, input logic v);
        @(posedge pclk);
        pins[p] <= v;
        repeat (6) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// File: test/tb.sv
`default_nettype none
`include "ifsb_regs.svh"
module tb
    import ifsb_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [`IFSB_ADDR_W-1:0] paddr;
    logic [31:0]             pwdata, prdata, d;
    logic [3:0]              pstrb;
    logic [79:0]             req;
    logic [2:0]              pins;
    ifsb_flag_t              bank [5];
    logic [32:0]             exp_q [$];
    int                      error_cnt = 0, n_checks = 0, cyc = 0, seed = 14, b;
    localparam logic [15:0] IMPL [5] = '{`IFSB_IMPL_BANK0, `IFSB_IMPL_BANK1,
        `IFSB_IMPL_BANK2, `IFSB_IMPL_BANK3, `IFSB_IMPL_BANK4};
    localparam logic [15:0] PIN [5] = '{16'h0001, 16'h2010, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [11:0] PADR [3] = '{12'h000, 12'h004, 12'h004};
    localparam logic [15:0] PBIT [3] = '{16'h0001, 16'h0010, 16'h2000};
    ifsb_src u_ifsb_src (.pclk(pclk), .req(req), .pins(pins));
    ifsb_top u_ifsb_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_pin0(pins[0]), .ext_pin1(pins[1]), .ext_pin2(pins[2]),
        .compare_ch1_req(req[2]), .capture_ch1_req(req[1]), .serial2_tx_req(req[31]),
        .serial2_rx_req(req[30]), .timer_five_req(req[28]), .timer_four_req(req[27]),
        .compare_ch4_req(req[26]), .compare_ch3_req(req[25]), .dma_ch2_done_req(req[24]),
        .capture_ch8_req(req[23]), .capture_ch7_req(req[22]), .change_notify_req(req[19]),
        .comparator_req(req[18]), .i2c_master_event_req(req[17]),
        .i2c_slave_event_req(req[16]), .dma_ch4_done_req(req[46]),
        .parallel_port_req(req[45]), .dma_ch3_done_req(req[36]), .can_event_req(req[35]),
        .can_rx_ready_req(req[34]), .spi_two_event_req(req[33]), .spi_two_error_req(req[32]),
        .calendar_clock_req(req[62]), .dma_ch5_done_req(req[61]),
        .codec_if_event_req(req[60]), .codec_if_error_req(req[59]), .dac_left_req(req[79]),
        .dac_right_req(req[78]), .can_tx_request_req(req[70]), .dma_ch7_done_req(req[69]),
        .dma_ch6_done_req(req[68]), .checksum_gen_req(req[67]), .serial2_error_req(req[66]),
        .serial1_error_req(req[65]), .irq_flags_bank_zero(bank[0]),
        .irq_flags_bank_one(bank[1]), .irq_flags_bank_two(bank[2]),
        .irq_flags_bank_three(bank[3]), .irq_flags_bank_four(bank[4]), .irq(irq));
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input logic [32:0] exp, input logic [32:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic final_report();
        if (exp_q.size() != 0)
            error_cnt++;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       input logic [3:0] s, input logic [32:0] e);
        int n;
        n = 0;
        exp_q.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge pclk);
        end
        if (n >= 20)
        begin
            error_cnt++;
            $display("[FAIL] %0t no ready from slave", $time);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] v, input logic e = 1'b0);
        apb(1'b0, a, 32'h0, 4'h0, {e, 16'h0, v});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s = 4'hF,
                      input logic e = 1'b0);
        apb(1'b1, a, v, s, {e, 32'h0});
    endtask
    task automatic irq_is(input logic v);
        repeat (2) @(negedge pclk);
        chk({32'h0, v}, {32'h0, irq});
    endtask
    always @(posedge pclk)
        if (psel && penable && pready)
            chk(exp_q.pop_front(), {pslverr, prdata});
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            final_report();
        end
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(12'(4 * i), 16'h0);
        for (int i = 0; i < 12; i++)
        begin
            b = $unsigned($random(seed)) % 5;
            d = $random(seed);
            wr(12'(4 * b), d);
            rd(12'(4 * b), d[15:0] & IMPL[b]);
        end
        for (int i = 0; i < 5; i++)
        begin
            wr(12'(4 * i), 32'hFFFFFFFF);
            rd(12'(4 * i), IMPL[i]);
            wr(12'(4 * i), 32'h0);
            rd(12'(4 * i), 16'h0);
        end
        wr(`IFSB_OFS_BANK1, 32'h0000FFFF, 4'h1);
        rd(`IFSB_OFS_BANK1, 16'h00DF);
        wr(`IFSB_OFS_BANK1, 32'h0);
        rd(`IFSB_OFS_EVT_STAT, 16'h0000);
        rd(`IFSB_OFS_EVT_STAT, 16'h0000);
        for (int i = 0; i < 80; i++)
            if (IMPL[i / 16][i % 16] && !PIN[i / 16][i % 16])
            begin
                u_ifsb_src.pulse(i);
                rd(12'(4 * (i / 16)), 16'h1 << (i % 16));
                wr(12'(4 * (i / 16)), 32'h0);
            end
        fork
            wr(`IFSB_OFS_BANK1, 32'h0);
            begin
                @(posedge pclk);
                u_ifsb_src.pulse(27);
            end
        join
        rd(`IFSB_OFS_BANK1, 16'h0800);
        wr(`IFSB_OFS_BANK1, 32'h0);
        rd(`IFSB_OFS_EVT_STAT, 16'h001F);
        u_ifsb_src.pulse(45);
        irq_is(1'b0);
        wr(`IFSB_OFS_EVT_MASK, 32'h2);
        irq_is(1'b0);
        u_ifsb_src.pulse(27);
        irq_is(1'b1);
        rd(`IFSB_OFS_EVT_STAT, 16'h0006);
        irq_is(1'b0);
        for (int p = 0; p < 6; p++)
        begin
            wr(`IFSB_OFS_POLARITY, 32'(p / 3) << (p % 3));
            u_ifsb_src.drive_pin(p % 3, 1'b0);
            wr(PADR[p % 3], 32'h0);
            for (int v = 1; v >= 0; v--)
            begin
                u_ifsb_src.drive_pin(p % 3, v[0]);
                rd(PADR[p % 3], ((v == 1) != (p >= 3)) ? PBIT[p % 3] : 16'h0);
                wr(PADR[p % 3], 32'h0);
            end
        end
        rd(12'h020, 16'h0, 1'b1);
        wr(12'hFFC, 32'hFFFFFFFF, 4'hF, 1'b1);
        repeat (2) @(posedge pclk);
        final_report();
    end
endmodule
bind ifsb_top ifsb_checker u_ifsb_checker (.*);
`default_nettype wire
